/* File: slx_bitmanip_map.vh */
// slx_bitmanip_map.vh - opcodes, widths and reset values of the
// shift / exponent / bit-field datapath.
// assumes: included by the datapath files only, definitions only.
`ifndef SLX_BITMANIP_MAP_VH
`define SLX_BITMANIP_MAP_VH

// operation codes from the instruction decoder
`define SLX_OP_NOP      4'h0
`define SLX_OP_MOVE_SHIFT_BY_AMOUNT     4'h1
`define SLX_OP_MOVE_SHIFT_BY_CONSTANT    4'h2
`define SLX_OP_SHFSV    4'h3
`define SLX_OP_EXP      4'h4
`define SLX_OP_NORMALIZE_STEP     4'h5
`define SLX_OP_SET      4'h6
`define SLX_OP_RST      4'h7
`define SLX_OP_TGL      4'h8
`define SLX_OP_TEST_BITS_ZERO     4'h9
`define SLX_OP_TEST_BITS_ONE     4'hA
`define SLX_OP_TEST_SINGLE_BIT     4'hB

// shift range held by the shift-amount register path
`define SLX_SHIFT_MAX16 16'h0024
`define SLX_SHIFT_MIN16 16'hFFDC
`define SLX_SHIFT_POS7  7'h24
`define SLX_SHIFT_NEG7  7'h5C
`define SLX_SHIFT_ONE7  7'h01
`define SLX_SHIFT_MONE7 7'h7F
`define SLX_SHIFT_ZERO7 7'h00

// exponent: leading sign bits minus this bias, referenced to bit 31
`define SLX_EXP_BIAS    6'h05
`define SLX_EXP_ONE     6'h01

// reset values
`define SLX_ACC_RST     36'h000000000
`define SLX_SV_RST      16'h0000
`define SLX_WORD_RST    16'h0000
`define SLX_FLAG_RST    1'b0

`endif

/* File: slx_barrel_shift.v */
// slx_barrel_shift.v - combinational signed-amount barrel shifter.
// assumes: amount already clamped to the legal range by the caller.
`timescale 1ns/100ps
`default_nettype none

module slx_barrel_shift #(
  parameter W  = 36,
  parameter AW = 7
) (
  // operand and control
  input  wire [W-1:0]  data_i,
  input  wire [AW-1:0] amount_i,
  input  wire          logical_i,
  // result
  output wire [W-1:0]  data_o
);

  wire [AW-1:0]       mag;
  wire signed [W-1:0] sdata;
  wire [W-1:0]        left_res;
  wire [W-1:0]        arith_res;
  wire [W-1:0]        logic_res;

  // negative count means right shift
  assign mag       = amount_i[AW-1] ? (~amount_i + 1'b1) : amount_i;
  assign sdata     = data_i;
  // left shift fills zeros in both modes
  assign left_res  = data_i << mag;
  // kept apart so the signed shift is not turned unsigned by a mux
  assign arith_res = sdata >>> mag;
  assign logic_res = data_i >> mag;
  assign data_o    = ~amount_i[AW-1] ? left_res :
                     (logical_i ? logic_res : arith_res);

endmodule // slx_barrel_shift

`default_nettype wire

/* File: slx_bitmanip_unit.v */
// slx_bitmanip_unit.v - shifted accumulator loads, exponent and
// normalization, bit-field set/clear/toggle/test for a 16-bit DSP core.
// assumes: single core clock; decoder holds op inputs while ready_o low
// only for new ops, and supplies memory/register words on operand_i.
`timescale 1ns/100ps
`default_nettype none
`include "slx_bitmanip_map.vh"

module slx_bitmanip_unit #(
  parameter ACC_W  = 36,
  parameter WORD_W = 16
) (
  // clock and reset
  input  wire              clock_i,
  input  wire              arst_n_i,
  // decoded operation
  input  wire              op_valid_i,
  input  wire [3:0]        op_code_i,
  input  wire [1:0]        acc_dst_sel_i,
  input  wire [1:0]        acc_src_sel_i,
  input  wire              src_is_acc_i,
  input  wire [WORD_W-1:0] operand_i,
  input  wire [4:0]        shift_const_i,
  input  wire [WORD_W-1:0] imm_mask_i,
  input  wire              mask_from_acc_i,
  input  wire [3:0]        bit_sel_i,
  input  wire              exp_to_acc_i,
  input  wire              exp_acc_sel_i,
  output wire              ready_o,
  output reg               done_o,
  // status_word_two shift-mode bit, high selects logical
  input  wire              shift_mode_logical_i,
  // general write port of shift_amount_reg
  input  wire              sv_wr_i,
  input  wire [WORD_W-1:0] sv_wdata_i,
  output wire [WORD_W-1:0] shift_amount_reg_o,
  // accumulators
  output wire [ACC_W-1:0]  acc0_o,
  output wire [ACC_W-1:0]  acc1_o,
  output wire [ACC_W-1:0]  acc2_o,
  output wire [ACC_W-1:0]  acc3_o,
  // read-modify-write result to register or memory
  output reg               wr_valid_o,
  output reg  [WORD_W-1:0] wr_data_o,
  // condition flags
  output wire              zero_flag_o,
  output wire              minus_flag_o,
  output wire              ext_flag_o
);

  localparam ST_IDLE   = 1'b0;
  localparam ST_SECOND = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // clamp shift_amount_reg to the +36..-36 window
  function [6:0] clamp_amt;
    input [15:0] v;
    begin
      if ($signed(v) > $signed(`SLX_SHIFT_MAX16))
        clamp_amt = `SLX_SHIFT_POS7;
      else if ($signed(v) < $signed(`SLX_SHIFT_MIN16))
        clamp_amt = `SLX_SHIFT_NEG7;
      else
        clamp_amt = v[6:0];
    end
  endfunction

  // leading copies of bit 35, counted from bit 35 down, minus bias
  function [5:0] exp_of;
    input [35:0] x;
    integer i;
    reg     stop;
    reg [5:0] n;
    begin
      n    = `SLX_EXP_ONE;
      stop = 1'b0;
      for (i = 34; i >= 0; i = i - 1) begin
        if (!stop && (x[i] == x[35]))
          n = n + `SLX_EXP_ONE;
        else
          stop = 1'b1;
      end
      exp_of = n - `SLX_EXP_BIAS;
    end
  endfunction

  // 16-bit word into the low part, extended per shift mode
  function [35:0] ext16;
    input [15:0] v;
    input        logical;
    begin
      if (logical)
        ext16 = {20'h00000, v};
      else
        ext16 = {{20{v[15]}}, v};
    end
  endfunction

  function [35:0] acc_flags_ext;
    input [35:0] v;
    begin
      acc_flags_ext = v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  reg              state_ff;
  reg [3:0]        lat_op_ff;
  reg [WORD_W-1:0] lat_data_ff;
  reg [WORD_W-1:0] lat_mask_ff;
  reg [ACC_W-1:0]  acc_ff [0:3];
  reg [WORD_W-1:0] sv_ff;
  reg              zero_ff;
  reg              minus_ff;
  reg              ext_ff;
  integer          k;

  ////////////////////////////////////////////////////////////////////////
  // sequencing

  wire take;
  wire is_rmw;
  wire is_mtest;
  wire two_cycle;
  wire [3:0] exec_op;

  assign ready_o   = (state_ff == ST_IDLE);
  assign take      = op_valid_i & ready_o;
  assign is_rmw    = (op_code_i == `SLX_OP_SET) ||
                     (op_code_i == `SLX_OP_RST) ||
                     (op_code_i == `SLX_OP_TGL);
  assign is_mtest  = (op_code_i == `SLX_OP_TEST_BITS_ZERO) ||
                     (op_code_i == `SLX_OP_TEST_BITS_ONE);
  // immediate mask needs the second instruction word
  assign two_cycle = is_rmw | (is_mtest & ~mask_from_acc_i);
  assign exec_op   = (state_ff == ST_SECOND) ? lat_op_ff :
                     ((take & ~two_cycle) ? op_code_i : `SLX_OP_NOP);

  ////////////////////////////////////////////////////////////////////////
  // shift and exponent datapath

  wire [ACC_W-1:0] acc_src;
  wire [ACC_W-1:0] exp_src;
  wire [5:0]       exp_val;
  wire [6:0]       amt_sv;
  wire [6:0]       amt_const;
  reg  [ACC_W-1:0] sh_data;
  reg  [6:0]       sh_amt;
  wire [ACC_W-1:0] sh_out;

  assign acc_src   = acc_ff[acc_src_sel_i];
  // 16-bit source sits at bits 16..31, sign copied up to bit 35
  assign exp_src   = (src_is_acc_i || exec_op == `SLX_OP_NORMALIZE_STEP) ? acc_src :
                     {{4{operand_i[15]}}, operand_i, 16'h0000};
  assign exp_val   = exp_of(exp_src);
  assign amt_sv    = clamp_amt(sv_ff);
  // opcode constant is 5-bit signed, +15..-16
  assign amt_const = {{2{shift_const_i[4]}}, shift_const_i};

  always @* begin
    sh_data = ext16(operand_i, shift_mode_logical_i);
    sh_amt  = `SLX_SHIFT_ZERO7;
    case (exec_op)
      `SLX_OP_MOVE_SHIFT_BY_AMOUNT: begin
        sh_amt = amt_sv;
      end
      `SLX_OP_MOVE_SHIFT_BY_CONSTANT: begin
        sh_amt = amt_const;
      end
      `SLX_OP_SHFSV: begin
        sh_data = acc_src;
        sh_amt  = amt_sv;
      end
      `SLX_OP_NORMALIZE_STEP: begin
        // one step toward normal form per issue
        sh_data = acc_src;
        if (exp_val[5])
          sh_amt = `SLX_SHIFT_MONE7;
        else if (exp_val != 6'h00)
          sh_amt = `SLX_SHIFT_ONE7;
        else
          sh_amt = `SLX_SHIFT_ZERO7;
      end
      default: begin
        sh_amt = `SLX_SHIFT_ZERO7;
      end
    endcase
  end

  slx_barrel_shift #(
    .W  (ACC_W),
    .AW (7)
  ) u_shift (
    .data_i    (sh_data),
    .amount_i  (sh_amt),
    .logical_i (shift_mode_logical_i),
    .data_o    (sh_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // bit-field datapath

  wire [WORD_W-1:0] bf_data;
  wire [WORD_W-1:0] bf_mask;
  wire [WORD_W-1:0] acc_mask;
  reg  [WORD_W-1:0] bf_res;
  wire [WORD_W-1:0] masked;

  // mask from the low word of a primary accumulator
  assign acc_mask = acc_ff[{1'b0, acc_src_sel_i[0]}][WORD_W-1:0];
  assign bf_data  = (state_ff == ST_SECOND) ? lat_data_ff : operand_i;
  assign bf_mask  = (state_ff == ST_SECOND) ? lat_mask_ff : acc_mask;
  assign masked   = bf_data & bf_mask;

  always @* begin
    case (exec_op)
      `SLX_OP_SET: bf_res = bf_data | bf_mask;
      `SLX_OP_RST: bf_res = bf_data & ~bf_mask;
      `SLX_OP_TGL: bf_res = bf_data ^ bf_mask;
      default:     bf_res = bf_data;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer registers

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff    <= ST_IDLE;
      lat_op_ff   <= `SLX_OP_NOP;
      lat_data_ff <= `SLX_WORD_RST;
      lat_mask_ff <= `SLX_WORD_RST;
      done_o      <= 1'b0;
    end else begin
      done_o <= (exec_op != `SLX_OP_NOP);
      case (state_ff)
        ST_IDLE: begin
          if (take && two_cycle) begin
            // read word and immediate mask held for the second cycle
            state_ff    <= ST_SECOND;
            lat_op_ff   <= op_code_i;
            lat_data_ff <= operand_i;
            lat_mask_ff <= imm_mask_i;
          end
        end
        default: begin
          state_ff  <= ST_IDLE;
          lat_op_ff <= `SLX_OP_NOP;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulators, shift_amount_reg and write-back

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (k = 0; k < 4; k = k + 1)
        acc_ff[k] <= `SLX_ACC_RST;
      sv_ff      <= `SLX_SV_RST;
      wr_valid_o <= 1'b0;
      wr_data_o  <= `SLX_WORD_RST;
    end else begin
      wr_valid_o <= 1'b0;
      case (exec_op)
        `SLX_OP_MOVE_SHIFT_BY_AMOUNT, `SLX_OP_MOVE_SHIFT_BY_CONSTANT, `SLX_OP_SHFSV: begin
          acc_ff[acc_dst_sel_i] <= sh_out;
        end
        `SLX_OP_NORMALIZE_STEP: begin
          acc_ff[acc_dst_sel_i] <= sh_out;
        end
        `SLX_OP_EXP: begin
          // source is only read here; with exp_to_acc_i the exponent overwrites it when exp_acc_sel_i picks that acc0/acc1
          sv_ff <= {{10{exp_val[5]}}, exp_val};
          if (exp_to_acc_i)
            acc_ff[{1'b0, exp_acc_sel_i}] <= {{30{exp_val[5]}}, exp_val};
        end
        `SLX_OP_SET, `SLX_OP_RST, `SLX_OP_TGL: begin
          wr_valid_o <= 1'b1;
          wr_data_o  <= bf_res;
        end
        default: begin
          wr_valid_o <= 1'b0;
        end
      endcase
      // exponent result wins over a plain write in the same cycle
      if (sv_wr_i && exec_op != `SLX_OP_EXP)
        sv_ff <= sv_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // condition flags

  wire [ACC_W-1:0] exp_acc;
  assign exp_acc = acc_flags_ext({{30{exp_val[5]}}, exp_val});

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      zero_ff  <= `SLX_FLAG_RST;
      minus_ff <= `SLX_FLAG_RST;
      ext_ff   <= `SLX_FLAG_RST;
    end else begin
      case (exec_op)
        `SLX_OP_MOVE_SHIFT_BY_AMOUNT, `SLX_OP_MOVE_SHIFT_BY_CONSTANT, `SLX_OP_SHFSV, `SLX_OP_NORMALIZE_STEP: begin
          zero_ff  <= (sh_out == `SLX_ACC_RST);
          minus_ff <= sh_out[35];
          // extension in use when bits 35..31 differ
          ext_ff   <= ~((&sh_out[35:31]) | ~(|sh_out[35:31]));
        end
        `SLX_OP_EXP: begin
          if (exp_to_acc_i) begin
            zero_ff  <= (exp_acc == `SLX_ACC_RST);
            minus_ff <= exp_acc[35];
            ext_ff   <= 1'b0;
          end
        end
        `SLX_OP_SET, `SLX_OP_RST, `SLX_OP_TGL: begin
          zero_ff  <= (bf_res == `SLX_WORD_RST);
          minus_ff <= bf_res[15];
        end
        `SLX_OP_TEST_BITS_ZERO: begin
          zero_ff <= (masked == `SLX_WORD_RST);
        end
        `SLX_OP_TEST_BITS_ONE: begin
          zero_ff <= (masked == bf_mask);
        end
        `SLX_OP_TEST_SINGLE_BIT: begin
          // set when the selected bit is clear
          zero_ff <= ~operand_i[bit_sel_i];
        end
        default: begin
          zero_ff <= zero_ff;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign shift_amount_reg_o = sv_ff;
  assign acc0_o             = acc_ff[0];
  assign acc1_o             = acc_ff[1];
  assign acc2_o             = acc_ff[2];
  assign acc3_o             = acc_ff[3];
  assign zero_flag_o        = zero_ff;
  assign minus_flag_o       = minus_ff;
  assign ext_flag_o         = ext_ff;

endmodule // slx_bitmanip_unit

`default_nettype wire

/* File: slx_bitmanip_props.sv */
// slx_bitmanip_props.sv - port-level timing and result checks.
// assumes: bound to slx_bitmanip_unit; one clock, async low reset.
`timescale 1ns/100ps
`default_nettype none

module slx_bitmanip_props #(
  parameter ACC_W  = 36,
  parameter WORD_W = 16
) (
  // clock and reset
  input wire logic              clock_i,
  input wire logic              arst_n_i,
  // decoded operation
  input wire logic              op_valid_i,
  input wire logic [3:0]        op_code_i,
  input wire logic              src_is_acc_i,
  input wire logic [WORD_W-1:0] operand_i,
  input wire logic [WORD_W-1:0] imm_mask_i,
  input wire logic              mask_from_acc_i,
  input wire logic [3:0]        bit_sel_i,
  input wire logic              exp_to_acc_i,
  // results
  input wire logic              ready_o,
  input wire logic              done_o,
  input wire logic [WORD_W-1:0] shift_amount_reg_o,
  input wire logic [ACC_W-1:0]  acc0_o,
  input wire logic [ACC_W-1:0]  acc1_o,
  input wire logic [ACC_W-1:0]  acc2_o,
  input wire logic [ACC_W-1:0]  acc3_o,
  input wire logic              wr_valid_o,
  input wire logic [WORD_W-1:0] wr_data_o,
  input wire logic              zero_flag_o,
  input wire logic              minus_flag_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  wire take = op_valid_i && ready_o;
  wire is_rmw = op_code_i inside {4'h6, 4'h7, 4'h8};
  wire is_tst = op_code_i inside {4'h9, 4'hA};
  wire two = take && (is_rmw || (is_tst && !mask_from_acc_i));
  wire one = take && (op_code_i inside {[4'h1:4'h5], 4'hB}
                      || (is_tst && mask_from_acc_i));

  // expected write-back and bit test, captured at the taking edge
  logic [WORD_W-1:0] rmw_ff;
  logic              bit_ff;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rmw_ff <= {WORD_W{1'b0}};
      bit_ff <= 1'b0;
    end else if (take) begin
      rmw_ff <= op_code_i == 4'h6 ? operand_i | imm_mask_i
              : op_code_i == 4'h7 ? operand_i & ~imm_mask_i
              : operand_i ^ imm_mask_i;
      bit_ff <= ~operand_i[bit_sel_i];
    end
  end

  property p_one;
    one |=> done_o && ready_o && !wr_valid_o;
  endproperty
  a_one: assert property (p_one) else $error("one-cycle op late");
  property p_two;
    two |=> !ready_o && !done_o ##1 done_o && ready_o;
  endproperty
  a_two: assert property (p_two) else $error("two-cycle timing");
  property p_rmw;
    take && is_rmw |=> ##1 wr_valid_o && wr_data_o == rmw_ff;
  endproperty
  a_rmw: assert property (p_rmw) else $error("write-back wrong");
  property p_wr_pulse;
    wr_valid_o |=> !wr_valid_o;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write held");
  property p_test_single_bit;
    take && op_code_i == 4'hB |=> zero_flag_o == bit_ff;
  endproperty
  a_test_single_bit: assert property (p_test_single_bit) else $error("bit test flag");
  property p_exp_sext;
    take && op_code_i == 4'h4 |=>
      shift_amount_reg_o[WORD_W-1:5] == {(WORD_W-5){shift_amount_reg_o[5]}};
  endproperty
  a_exp_sext: assert property (p_exp_sext) else $error("exp not sext");
  property p_exp_word;
    take && op_code_i == 4'h4 && !src_is_acc_i |=>
      shift_amount_reg_o <= 16'h001F;
  endproperty
  a_exp_word: assert property (p_exp_word) else $error("word exp range");
  property p_exp_keep;
    take && op_code_i == 4'h4 && !exp_to_acc_i |=>
      $stable({acc0_o, acc1_o, acc2_o, acc3_o});
  endproperty
  a_exp_keep: assert property (p_exp_keep) else $error("exp moved acc");
  property p_test_keep;
    take && (is_tst || op_code_i == 4'hB) |=> $stable(minus_flag_o) &&
      $stable({acc0_o, acc1_o, acc2_o, acc3_o, shift_amount_reg_o});
  endproperty
  a_test_keep: assert property (p_test_keep) else $error("test wrote");
endmodule // slx_bitmanip_props

bind slx_bitmanip_unit slx_bitmanip_props #(
  .ACC_W(ACC_W), .WORD_W(WORD_W)) u_props (
  .clock_i, .arst_n_i, .op_valid_i, .op_code_i, .src_is_acc_i, .operand_i,
  .imm_mask_i, .mask_from_acc_i, .bit_sel_i, .exp_to_acc_i, .ready_o,
  .done_o, .shift_amount_reg_o, .acc0_o, .acc1_o, .acc2_o, .acc3_o,
  .wr_valid_o, .wr_data_o, .zero_flag_o, .minus_flag_o);
`default_nettype wire

/* File: shift_load_exponent_bitfield_test.sv */
// shift_load_exponent_bitfield_test.sv - bench against a behavioural model.
// assumes: design and checker compiled first; single 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module shift_load_exponent_bitfield_test;
  logic        clock_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        op_valid_i = 1'b0;
  logic [3:0]  op_code_i = 4'h0;
  logic [1:0]  acc_dst_sel_i = 2'h0;
  logic [1:0]  acc_src_sel_i = 2'h0;
  logic        src_is_acc_i = 1'b0;
  logic [15:0] operand_i = 16'h0000;
  logic [4:0]  shift_const_i = 5'h00;
  logic [15:0] imm_mask_i = 16'h0000;
  logic        mask_from_acc_i = 1'b0;
  logic [3:0]  bit_sel_i = 4'h0;
  logic        exp_to_acc_i = 1'b0;
  logic        exp_acc_sel_i = 1'b0;
  logic        shift_mode_logical_i = 1'b0;
  logic        sv_wr_i = 1'b0;
  logic [15:0] sv_wdata_i = 16'h0000;
  wire         ready_o, done_o, wr_valid_o;
  wire         zero_flag_o, minus_flag_o, ext_flag_o;
  wire  [15:0] shift_amount_reg_o, wr_data_o;
  wire  [35:0] acc0_o, acc1_o, acc2_o, acc3_o;
  logic [35:0] m_acc [4];
  logic [35:0] t;
  logic [15:0] m_sv, m_wr, mk;
  logic        m_z, m_n, m_e;
  int          miscompares = 0;
  int          n_checks = 0;
  int          i;
  // amount edges: zero, +-1, +-36, beyond range (clamped), odd values
  logic [15:0] svt [10] = '{16'h0000, 16'h0001, 16'hFFFF, 16'h0024,
    16'hFFDC, 16'h0028, 16'hFFD8, 16'h0011, 16'hFFEC, 16'h0023};

  slx_bitmanip_unit u_dut (
    .clock_i, .arst_n_i, .op_valid_i, .op_code_i, .acc_dst_sel_i,
    .acc_src_sel_i, .src_is_acc_i, .operand_i, .shift_const_i, .imm_mask_i,
    .mask_from_acc_i, .bit_sel_i, .exp_to_acc_i, .exp_acc_sel_i, .ready_o,
    .done_o, .shift_mode_logical_i, .sv_wr_i, .sv_wdata_i,
    .shift_amount_reg_o, .acc0_o, .acc1_o, .acc2_o, .acc3_o, .wr_valid_o,
    .wr_data_o, .zero_flag_o, .minus_flag_o, .ext_flag_o);

  initial begin
    forever #12.5 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [35:0] shf(input logic [35:0] v, input int n);
    if (n >= 0) return v << n;
    if (shift_mode_logical_i) return v >> (-n);
    return 36'($signed(v) >>> (-n));
  endfunction

  function automatic int expo(input logic [35:0] v);
    int n;
    n = 0;
    while (n < 36 && v[35-n] == v[35]) n++;
    return n - 5;
  endfunction

  function automatic logic [35:0] dacc(input int n);
    return n == 0 ? acc0_o : n == 1 ? acc1_o : n == 2 ? acc2_o : acc3_o;
  endfunction

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic set_sv(input logic [15:0] v);
    @(negedge clock_i);
    sv_wr_i = 1'b1;
    sv_wdata_i = v;
    m_sv = v;
    @(negedge clock_i);
    sv_wr_i = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // fl = {src_is_acc, mask_from_acc, exp_to_acc, exp_acc_sel}
  task automatic run_op(input [3:0] op, input [15:0] opd, input [15:0] msk,
    input [1:0] dst, input [1:0] src, input [4:0] k, input [3:0] fl);
    logic [35:0] w, r;
    logic        ld, rmw;
    int          s, e, j;
    @(negedge clock_i);
    op_valid_i = 1'b1;
    op_code_i = op;
    operand_i = opd;
    imm_mask_i = msk;
    acc_dst_sel_i = dst;
    acc_src_sel_i = src;
    shift_const_i = k;
    bit_sel_i = k[3:0];
    {src_is_acc_i, mask_from_acc_i, exp_to_acc_i, exp_acc_sel_i} = fl;
    w = shift_mode_logical_i ? {20'h00000, opd} : {{20{opd[15]}}, opd};
    s = $signed(m_sv);
    s = s > 36 ? 36 : (s < -36 ? -36 : s);
    ld = 1'b1;
    r = 36'h000000000;
    rmw = op inside {4'h6, 4'h7, 4'h8};
    e = expo(m_acc[src]);
    case (op)
      4'h1: r = shf(w, s);
      4'h2: r = shf(w, $signed(k));
      4'h3: r = shf(m_acc[src], s);
      4'h5: r = shf(m_acc[src], e > 0 ? 1 : (e < 0 ? -1 : 0));
      default: ld = 1'b0;
    endcase
    if (op == 4'h4) begin
      e = expo(fl[3] ? m_acc[src] : {{4{opd[15]}}, opd, 16'h0000});
      m_sv = 16'(e);
      if (fl[1]) begin
        m_acc[{1'b0, fl[0]}] = 36'(e);
        {m_z, m_n, m_e} = {e == 0, e < 0, 1'b0};
      end
    end
    if (rmw) begin
      m_wr = op == 4'h6 ? opd | msk : (op == 4'h7 ? opd & ~msk : opd ^ msk);
      {m_z, m_n} = {m_wr == 16'h0000, m_wr[15]};
    end
    mk = fl[2] ? m_acc[{1'b0, src[0]}][15:0] : msk;
    if (op == 4'h9) m_z = (opd & mk) == 16'h0000;
    if (op == 4'hA) m_z = (opd & mk) == mk;
    if (op == 4'hB) m_z = ~opd[k[3:0]];
    if (ld) begin
      m_acc[dst] = r;
      {m_z, m_n, m_e} = {r == 36'h0, r[35], r[35:31] != {5{r[35]}}};
    end
    @(negedge clock_i);
    op_valid_i = 1'b0;
    j = 0;
    while (done_o !== 1'b1 && j < 3) begin
      @(negedge clock_i);
      j++;
    end
    if (done_o !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    check(wr_valid_o, rmw);
    if (rmw) check(wr_data_o, m_wr);
    for (j = 0; j < 4; j++) check(dacc(j), m_acc[j]);
    check(shift_amount_reg_o, m_sv);
    check({zero_flag_o, minus_flag_o, ext_flag_o}, {m_z, m_n, m_e});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(62607));
    for (i = 0; i < 4; i++) m_acc[i] = 36'h000000000;
    {m_sv, m_wr, m_z, m_n, m_e} = 35'h000000000;
    repeat (20) @(negedge clock_i);
    arst_n_i = 1'b1;
    check({ready_o, done_o, wr_valid_o, zero_flag_o}, 4'h8);
    // word loads over every amount edge, each in both modes
    for (i = 0; i < 20; i++) begin
      set_sv(svt[i / 2]);
      shift_mode_logical_i = i[0];
      run_op(4'h1, 16'($urandom), 16'h0000, 2'(i), 2'h0, 5'h00, 4'h0);
    end
    for (i = 0; i < 32; i++) begin
      shift_mode_logical_i = 1'($urandom);
      run_op(4'h2, 16'($urandom), 16'h0000, 2'(i), 2'h0, 5'(i), 4'h0);
    end
    // right steps in normalization rely on sign fill
    shift_mode_logical_i = 1'b0;
    for (i = 0; i < 2; i++)
      run_op(4'h4, {16{i[0]}}, 16'h0000, 2'h0, 2'h0, 5'h00, 4'h0);
    for (i = 0; i < 16; i++) begin
      run_op(4'h4, 16'($urandom), 16'h0000, 2'h0, 2'(i), 5'h00,
             {i[0], 1'b0, i[1], i[2]});
      if (i[0] && !i[1] && m_acc[i % 4] != 36'h0) begin
        run_op(4'h3, 16'h0000, 16'h0000, 2'(i + 1), 2'(i), 5'h00, 4'h0);
        t = dacc((i + 1) % 4);
        check(t[31] ^ t[30], 1'b1);
      end
    end
    for (i = 0; i < 8; i++)
      run_op(4'h5, 16'h0000, 16'h0000, 2'($urandom), 2'(i), 5'h00, 4'h0);
    for (i = 0; i < 12; i++)
      run_op(4'(6 + i % 3), 16'($urandom), 16'($urandom), 2'h0, 2'h0,
             5'h00, 4'h0);
    // masked tests, operand equal to mask in iterations 4..7 of both kinds
    for (i = 0; i < 8; i++) begin
      mk = 16'($urandom);
      run_op(4'(9 + i % 2), i[2] ? mk : 16'($urandom), mk, 2'h0,
             2'($urandom), 5'h00, {1'b0, i[1], 2'h0});
    end
    for (i = 0; i < 16; i++)
      run_op(4'hB, 16'($urandom), 16'h0000, 2'h0, 2'h0, 5'(i), 4'h0);
    finish_test();
  end
endmodule // shift_load_exponent_bitfield_test
`default_nettype wire
